// ===== core/drt_pkg.sv
// constants for the refresh bookkeeping and latency selection of the memory die
// assumes a single 100 MHz clock and a controller that drives commands on that clock
package drt_pkg;
    localparam int CLOCK_MHZ = 100;

    localparam int REFRESH_WINDOW_TIME_MS_T0 = 32;
    localparam int REFRESH_WINDOW_TIME_MS_T1 = 16;
    localparam int REFRESH_WINDOW_TIME_MS_T2 = 8;
    localparam int REFRESH_COMMANDS_PER_WINDOW = 8192;

    // intervals in ps; longest times round down to whole cycles
    localparam int ALLBANK_REFRESH_INTERVAL_PS_T0 = 3900000;
    localparam int ALLBANK_REFRESH_INTERVAL_PS_T1 = 1950000;
    localparam int ALLBANK_REFRESH_INTERVAL_PS_T2 = 975000;
    localparam int PERBANK_REFRESH_INTERVAL_PS_T0 = 487500;
    localparam int PERBANK_REFRESH_INTERVAL_PS_T1 = 243750;
    localparam int PERBANK_REFRESH_INTERVAL_PS_T2 = 121875;
    localparam int PERBANK_CYC_T0 = PERBANK_REFRESH_INTERVAL_PS_T0 * CLOCK_MHZ / 1000000;
    localparam int PERBANK_CYC_T1 = PERBANK_REFRESH_INTERVAL_PS_T1 * CLOCK_MHZ / 1000000;
    localparam int PERBANK_CYC_T2 = PERBANK_REFRESH_INTERVAL_PS_T2 * CLOCK_MHZ / 1000000;

    // least times round up
    localparam int ALLBANK_REFRESH_CYCLE_TIME_NS = 210;
    localparam int PERBANK_REFRESH_CYCLE_TIME_NS = 90;
    localparam int ALLBANK_BUSY_CYC = (ALLBANK_REFRESH_CYCLE_TIME_NS * CLOCK_MHZ + 999) / 1000;
    localparam int PERBANK_BUSY_CYC = (PERBANK_REFRESH_CYCLE_TIME_NS * CLOCK_MHZ + 999) / 1000;

    localparam int NUM_BANKS = 8;
    localparam int BANKS_PER_ALLBANK = 8;
    localparam int OWED_LIMIT = 64;

    localparam int FREQ_STEPS = 9;
    localparam logic [3:0] FREQ_IDX_MAX = 4'h8;
    localparam logic [3:0] FREQ_IDX_RESET = 4'h6;
    localparam int MR0_RL3_BIT = 7;
    localparam int MR0_SETB_BIT = 6;

    // columns: 166,400,533,600,667,733,800,933,1066 MHz
    localparam logic [4:0] READ_DELAY_TABLE [0:FREQ_STEPS-1] =
        '{5'h03, 5'h06, 5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0e, 5'h10};
    localparam logic [4:0] WRITE_DELAY_SET_A [0:FREQ_STEPS-1] =
        '{5'h01, 5'h03, 5'h04, 5'h05, 5'h06, 5'h06, 5'h06, 5'h08, 5'h08};
    localparam logic [4:0] WRITE_DELAY_SET_B [0:FREQ_STEPS-1] =
        '{5'h01, 5'h03, 5'h04, 5'h05, 5'h08, 5'h09, 5'h09, 5'h0b, 5'h0d};
endpackage

// ===== core/drt_refresh_latency.sv
// refresh-cycle busy tracking, refresh debt accounting and latency selection
// assumes commands arrive as one-cycle pulses from controller logic on ref_clk_i
`timescale 1ns/1ps
module drt_refresh_latency #(
    parameter bit RL3_SUPPORTED = 1'b1,
    parameter bit SETB_SUPPORTED = 1'b1
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic [1:0] temp_range_i,
    input wire logic all_bank_refresh_command_i,
    input wire logic single_bank_refresh_command_i,
    input wire logic [2:0] refresh_bank_i,
    input wire logic latency_apply_i,
    input wire logic [3:0] freq_index_i,
    input wire logic alt_write_set_i,
    output logic [4:0] read_return_delay_o,
    output logic [4:0] write_accept_delay_o,
    output logic latency_error_o,
    output logic [7:0] mode_reg0_o,
    output logic allbank_busy_o,
    output logic [drt_pkg::NUM_BANKS-1:0] perbank_busy_o,
    output logic refresh_overdue_o,
    output logic refresh_conflict_o
);
    import drt_pkg::*;

    typedef struct packed {
        logic [4:0] rd_lat;
        logic [4:0] wr_lat;
        logic lat_err;
        logic [4:0] ab_cnt;
        logic [NUM_BANKS-1:0][3:0] pb_cnt;
        logic [5:0] tick_cnt;
        logic [7:0] owed;
        logic conflict;
    } drt_state_type;

    drt_state_type state;
    drt_state_type next_state;
    logic legal;
    logic tick;
    logic [5:0] period_last;
    logic [9:0] owed_sum;
    logic [9:0] owed_sub;

    // a refused request keeps the old delays, so running traffic never sees a bad pair
    always_comb begin
        legal = (freq_index_i <= FREQ_IDX_MAX);
        if (freq_index_i == 4'h0 && !RL3_SUPPORTED) begin
            legal = 1'b0;
        end
        if (alt_write_set_i && !SETB_SUPPORTED) begin
            legal = 1'b0;
        end
    end

    // a hot part shortens the interval at once; the far side handles early switching
    always_comb begin
        case (temp_range_i)
            2'h0: period_last = 6'(PERBANK_CYC_T0 - 1);
            2'h1: period_last = 6'(PERBANK_CYC_T1 - 1);
            default: period_last = 6'(PERBANK_CYC_T2 - 1);
        endcase
    end

    // the counter is not cleared on a range change, so the first hotter tick may come early
    assign tick = (state.tick_cnt >= period_last);

    always_comb begin
        next_state = state;
        owed_sum = 10'(state.owed) + {9'h000, tick};
        owed_sub = 10'h000;
        if (latency_apply_i) begin
            if (legal) begin
                next_state.rd_lat = READ_DELAY_TABLE[freq_index_i];
                next_state.wr_lat = alt_write_set_i ? WRITE_DELAY_SET_B[freq_index_i]
                                                    : WRITE_DELAY_SET_A[freq_index_i];
                next_state.lat_err = 1'b0;
            end else begin
                next_state.lat_err = 1'b1;
            end
        end
        next_state.tick_cnt = tick ? 6'h00 : state.tick_cnt + 6'h01;
        // debt counted in per-bank units so both command kinds share one counter
        if (all_bank_refresh_command_i) begin
            owed_sub = owed_sub + 10'(BANKS_PER_ALLBANK);
        end
        if (single_bank_refresh_command_i) begin
            owed_sub = owed_sub + 10'h001;
        end
        // saturate instead of wrapping so a long stall still reads as overdue
        if (owed_sub >= owed_sum) begin
            next_state.owed = 8'h00;
        end else if (owed_sum - owed_sub > 10'h0ff) begin
            next_state.owed = 8'hff;
        end else begin
            next_state.owed = 8'(owed_sum - owed_sub);
        end
        if (state.ab_cnt != 5'h00) begin
            next_state.ab_cnt = state.ab_cnt - 5'h01;
        end
        for (int b = 0; b < NUM_BANKS; b++) begin
            if (state.pb_cnt[b] != 4'h0) begin
                next_state.pb_cnt[b] = state.pb_cnt[b] - 4'h1;
            end
        end
        // an all-bank refresh inside any running cycle, or a per-bank one inside an all-bank cycle or its own bank's, is flagged, then reloads its own busy count
        if (all_bank_refresh_command_i) begin
            if (allbank_busy_o || perbank_busy_o != '0) begin
                next_state.conflict = 1'b1;
            end
            next_state.ab_cnt = 5'(ALLBANK_BUSY_CYC);
        end
        if (single_bank_refresh_command_i) begin
            if (allbank_busy_o || perbank_busy_o[refresh_bank_i]) begin
                next_state.conflict = 1'b1;
            end
            next_state.pb_cnt[refresh_bank_i] = 4'(PERBANK_BUSY_CYC);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            // reset lands on the 800 MHz default set
            state <= '0;
            state.rd_lat <= READ_DELAY_TABLE[FREQ_IDX_RESET];
            state.wr_lat <= WRITE_DELAY_SET_A[FREQ_IDX_RESET];
        end else begin
            state <= next_state;
        end
    end

    assign read_return_delay_o = state.rd_lat;
    assign write_accept_delay_o = state.wr_lat;
    assign latency_error_o = state.lat_err;
    always_comb begin
        mode_reg0_o = 8'h00;
        mode_reg0_o[MR0_RL3_BIT] = RL3_SUPPORTED;
        mode_reg0_o[MR0_SETB_BIT] = SETB_SUPPORTED;
    end
    assign allbank_busy_o = (state.ab_cnt != 5'h00);
    always_comb begin
        for (int b = 0; b < NUM_BANKS; b++) begin
            perbank_busy_o[b] = (state.pb_cnt[b] != 4'h0);
        end
    end
    assign refresh_overdue_o = (state.owed > 8'(OWED_LIMIT));
    assign refresh_conflict_o = state.conflict;

    // latency selection checks
    chk_read_delay_load: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        latency_apply_i && legal |=> read_return_delay_o == READ_DELAY_TABLE[$past(freq_index_i)])
        else $error("read delay not loaded from table");
    chk_setb_write: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        latency_apply_i && legal && alt_write_set_i
        |=> write_accept_delay_o == WRITE_DELAY_SET_B[$past(freq_index_i)])
        else $error("alternate write delay wrong");
    chk_rl3_refused: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        latency_apply_i && freq_index_i == 4'h0 && !mode_reg0_o[MR0_RL3_BIT]
        |=> latency_error_o && $stable(read_return_delay_o))
        else $error("unsupported lowest pair accepted");
    chk_setb_refused: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        latency_apply_i && alt_write_set_i && !mode_reg0_o[MR0_SETB_BIT]
        |=> latency_error_o && $stable(write_accept_delay_o))
        else $error("unsupported alternate set accepted");
    chk_delay_hold: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        !latency_apply_i |=> $stable(read_return_delay_o) && $stable(write_accept_delay_o))
        else $error("latency changed without apply");
    chk_seta_write: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        latency_apply_i && legal && !alt_write_set_i
        |=> write_accept_delay_o == WRITE_DELAY_SET_A[$past(freq_index_i)])
        else $error("default write delay wrong");
    chk_refuse_flag: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        latency_apply_i && !legal
        |=> latency_error_o && $stable(read_return_delay_o) && $stable(write_accept_delay_o))
        else $error("refused request changed the delays");
    chk_accept_clears: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        latency_apply_i && legal |=> !latency_error_o)
        else $error("accepted request left the error flag set");

    // refresh cycle and debt checks
    chk_allbank_busy: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        all_bank_refresh_command_i
        |=> allbank_busy_o[*8] ##1 allbank_busy_o[*8] ##1 allbank_busy_o[*5])
        else $error("all-bank busy shorter than cycle time");
    chk_allbank_end: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        all_bank_refresh_command_i ##1 (!all_bank_refresh_command_i)[*8]
        ##1 (!all_bank_refresh_command_i)[*8] ##1 (!all_bank_refresh_command_i)[*5]
        |=> !allbank_busy_o)
        else $error("all-bank busy outlasts cycle time");
    chk_perbank_busy: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        single_bank_refresh_command_i
        |=> (perbank_busy_o != '0)[*8] ##1 (perbank_busy_o != '0))
        else $error("per-bank busy shorter than cycle time");
    chk_perbank_end: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        single_bank_refresh_command_i && !all_bank_refresh_command_i
        ##1 (!single_bank_refresh_command_i && !all_bank_refresh_command_i)[*8]
        ##1 (!single_bank_refresh_command_i && !all_bank_refresh_command_i)
        |=> perbank_busy_o == '0)
        else $error("per-bank busy stuck");
    chk_pb_overlap: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        single_bank_refresh_command_i && perbank_busy_o[refresh_bank_i] |=> refresh_conflict_o)
        else $error("per-bank overlap not flagged");
    chk_conflict_sticky: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        refresh_conflict_o |=> refresh_conflict_o)
        else $error("conflict flag dropped before reset");
    chk_debt_tick: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        tick && !all_bank_refresh_command_i && !single_bank_refresh_command_i
        && state.owed != 8'hff |=> state.owed == $past(state.owed) + 8'h01)
        else $error("refresh debt did not grow");
    chk_debt_payment: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        all_bank_refresh_command_i && !single_bank_refresh_command_i && !tick
        && state.owed >= 8'(BANKS_PER_ALLBANK)
        |=> state.owed == $past(state.owed) - 8'(BANKS_PER_ALLBANK))
        else $error("all-bank refresh did not pay its debt");

    cov_setb_used: cover property (@(posedge ref_clk_i) latency_apply_i && legal && alt_write_set_i);
    cov_overdue: cover property (@(posedge ref_clk_i) $rose(refresh_overdue_o));
    cov_conflict: cover property (@(posedge ref_clk_i) $rose(refresh_conflict_o));
    cov_rl3_refused: cover property (@(posedge ref_clk_i) latency_apply_i && freq_index_i == 4'h0 && !legal);
    cov_pb_overlap: cover property (@(posedge ref_clk_i) single_bank_refresh_command_i && perbank_busy_o[refresh_bank_i]);
endmodule // drt_refresh_latency

// ===== verification/drt_host_model.sv
// controller-side model: drives refresh and latency requests on falling edges
// assumes the bench calls one task at a time and keeps refresh spacing itself
`timescale 1ns/1ps
module drt_host_model (
    input wire logic ref_clk_i,
    output logic [1:0] temp_range_o,
    output logic ab_cmd_o,
    output logic pb_cmd_o,
    output logic [2:0] bank_o,
    output logic apply_o,
    output logic [3:0] freq_o,
    output logic alt_o
);
    initial begin
        {temp_range_o, ab_cmd_o, pb_cmd_o, bank_o, apply_o, freq_o, alt_o} = '0;
    end
    // reported range picks the interval the debt counter must keep up with
    task automatic temp(input logic [1:0] t);
        @(negedge ref_clk_i);
        temp_range_o = t;
    endtask
    // kind 0 all-bank, 1 per-bank, 2 latency apply; one-cycle pulse
    task automatic pulse(input logic [1:0] kind, input logic [3:0] arg, input logic alt);
        @(negedge ref_clk_i);
        ab_cmd_o = kind == 2'h0;
        pb_cmd_o = kind == 2'h1;
        apply_o = kind == 2'h2;
        bank_o = arg[2:0];
        freq_o = arg;
        alt_o = alt;
        @(negedge ref_clk_i);
        {ab_cmd_o, pb_cmd_o, apply_o} = '0;
        // qualifiers are meaningless once the pulse is gone
        bank_o = ~arg[2:0];
        freq_o = ~arg;
        alt_o = ~alt;
    endtask
endmodule // drt_host_model

// ===== verification/drt_refresh_latency_tb.sv
// self-checking bench for refresh busy, debt and latency selection
// assumes one instance with both optional latency features, a second one with neither
`timescale 1ns/1ps
module drt_refresh_latency_tb;
    logic ref_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [1:0] tr;
    logic ab, pb, ap, alt;
    logic [2:0] bk;
    logic [3:0] fq;
    logic [4:0] rd, wr;
    logic err, abb, ovd, cfl;
    logic [7:0] mr0, pbb;
    logic err2;
    logic [4:0] rd2, wr2;
    logic [7:0] mr2;
    int n_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    int n, bank;
    int rd_tab[9] = '{3, 6, 8, 9, 10, 11, 12, 14, 16};
    int wa_tab[9] = '{1, 3, 4, 5, 6, 6, 6, 8, 8};
    int wb_tab[9] = '{1, 3, 4, 5, 8, 9, 9, 11, 13};
    drt_host_model i_host (.ref_clk_i(ref_clk_i), .temp_range_o(tr), .ab_cmd_o(ab),
        .pb_cmd_o(pb), .bank_o(bk), .apply_o(ap), .freq_o(fq), .alt_o(alt));
    drt_refresh_latency i_dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .temp_range_i(tr),
        .all_bank_refresh_command_i(ab), .single_bank_refresh_command_i(pb),
        .refresh_bank_i(bk), .latency_apply_i(ap), .freq_index_i(fq), .alt_write_set_i(alt),
        .read_return_delay_o(rd), .write_accept_delay_o(wr), .latency_error_o(err),
        .mode_reg0_o(mr0), .allbank_busy_o(abb), .perbank_busy_o(pbb),
        .refresh_overdue_o(ovd), .refresh_conflict_o(cfl));
    drt_refresh_latency #(.RL3_SUPPORTED(1'b0), .SETB_SUPPORTED(1'b0)) i_dut_bare (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i), .temp_range_i(tr),
        .all_bank_refresh_command_i(ab), .single_bank_refresh_command_i(pb),
        .refresh_bank_i(bk), .latency_apply_i(ap), .freq_index_i(fq), .alt_write_set_i(alt),
        .read_return_delay_o(rd2), .write_accept_delay_o(wr2), .latency_error_o(err2),
        .mode_reg0_o(mr2), .allbank_busy_o(), .perbank_busy_o(),
        .refresh_overdue_o(), .refresh_conflict_o());
    always #5 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            end_sim();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t: got %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // b == 8 means the all-bank flag
    task automatic busy_len(input int b, input int exp);
        int k;
        k = 0;
        while ((b == 8 ? abb : pbb[b]) === 1'b1 && k < 40) begin
            k++;
            @(negedge ref_clk_i);
        end
        check(k, exp);
    endtask
    initial begin
        void'($urandom(32'h1cef));
        repeat (3) @(negedge ref_clk_i);
        reset_i = 1'b0;
        check(rd, 12);
        check(wr, 6);
        check(mr0, 8'hc0);
        check(mr2, 8'h00);
        check({err, abb, pbb, ovd, cfl}, 0);
        for (int i = 0; i < 18; i++) begin
            i_host.pulse(2'h2, 4'(i % 9), 1'(i / 9));
            check(rd, rd_tab[i % 9]);
            check(wr, i < 9 ? wa_tab[i % 9] : wb_tab[i % 9]);
            check(err, 0);
            check(err2, i == 0 || i >= 9);
        end
        // refused index leaves the last good setting in place
        i_host.pulse(2'h2, 4'(9 + $urandom % 7), 1'b0);
        check({err, rd, wr}, {1'b1, 5'h10, 5'h0d});
        i_host.pulse(2'h2, 4'h7, 1'b1);
        check({err, rd, wr}, {1'b0, 5'h0e, 5'h0b});
        check({err2, rd2, wr2}, {1'b1, 5'h10, 5'h08});
        // lowest pair: taken where supported, refused where not
        i_host.pulse(2'h2, 4'h0, 1'b0);
        check({err, rd, wr, err2, rd2, wr2}, {1'b0, 5'h03, 5'h01, 1'b1, 5'h10, 5'h08});
        i_host.pulse(2'h0, 4'h0, 1'b0);
        busy_len(8, 210 / 10);
        bank = $urandom % 8;
        i_host.pulse(2'h1, 4'(bank), 1'b0);
        check(pbb, 8'h01 << bank);
        busy_len(bank, (90 + 9) / 10);
        check(cfl, 0);
        // long interval at low temperature must not run up debt this fast
        repeat (800) @(negedge ref_clk_i);
        check(ovd, 0);
        i_host.temp(2'h2);
        n = 0;
        while (ovd !== 1'b1 && n < 1000) begin
            n++;
            @(negedge ref_clk_i);
        end
        check(n > 540 && n < 800, 1);
        repeat (4) begin
            i_host.pulse(2'h0, 4'h0, 1'b0);
            repeat (21) @(negedge ref_clk_i);
        end
        check(ovd, 0);
        i_host.pulse(2'h1, 4'(bank), 1'b0);
        i_host.pulse(2'h1, 4'(bank), 1'b0);
        check(cfl, 1);
        repeat (30) @(negedge ref_clk_i);
        check(cfl, 1);
        reset_i = 1'b1;
        @(negedge ref_clk_i);
        reset_i = 1'b0;
        check({cfl, rd, wr}, {1'b0, 5'h0c, 5'h06});
        // middle range: debt starts from zero and grows one unit per 24 cycles
        i_host.temp(2'h1);
        n = 0;
        while (ovd !== 1'b1 && n < 2000) begin
            n++;
            @(negedge ref_clk_i);
        end
        check(n > 1540 && n < 1580, 1);
        end_sim();
    end
endmodule // drt_refresh_latency_tb
